// [rtl/mle_pkg.sv]
// package of offsets, layouts and types for the mdio link/command events
package mle_pkg;
	// ========================================
	// sizes
	localparam int NUM_PHY = 32;
	localparam int NUM_CH = 2;
	localparam int PHY_AW = 5;
	localparam int BUS_AW = 8;

	// ========================================
	// register byte offsets
	localparam logic [7:0] OFS_CONN_STATE = 8'h00;
	localparam logic [7:0] OFS_LINK_RAW = 8'h04;
	localparam logic [7:0] OFS_LINK_MASKED = 8'h08;
	localparam logic [7:0] OFS_CMD_RAW = 8'h0c;
	localparam logic [7:0] OFS_CMD_MASKED = 8'h10;
	localparam logic [7:0] OFS_CMD_MASK_SET = 8'h14;
	localparam logic [7:0] OFS_CMD_MASK_CLR = 8'h18;
	localparam logic [7:0] OFS_LINK_IRQ_EN = 8'h1c;
	localparam logic [7:0] OFS_PHY_SEL0 = 8'h20;
	localparam logic [7:0] OFS_PHY_SEL1 = 8'h24;
	localparam logic [7:0] OFS_CMD_CH0 = 8'h28;
	localparam logic [7:0] OFS_CMD_CH1 = 8'h2c;

	// ========================================
	// field positions
	localparam int GO_BIT = 31;

	// ========================================
	// reset values
	localparam logic [31:0] RST_CONN_STATE = 32'h0000_0000;
	localparam logic [1:0] RST_EVENTS = 2'h0;
	localparam logic [1:0] RST_ENABLES = 2'h0;
	localparam logic [4:0] RST_PHY_SEL = 5'h00;

	// ========================================
	// types
	// one finished read of a phy's generic status register
	typedef struct packed {
		logic valid;
		logic [PHY_AW-1:0] phy_addr;
		logic ack;
		logic link_up;
	} mle_status_rpt_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [BUS_AW-1:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} mle_avs_req_t;

	typedef enum logic {
		BUS_WAIT,
		BUS_SERVE
	} mle_bus_state_t;
endpackage : mle_pkg

// [rtl/mle_events.sv]
// connection-state vector, link and command events, avalon register slave
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module mle_events
	import mle_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// avalon-mm slave
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [BUS_AW-1:0] avs_address_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// from the mdio frame engine
	input wire mle_status_rpt_t status_rpt_i,
	input wire logic [NUM_CH-1:0] cmd_done_i,
	// to the mdio frame engine
	output logic [NUM_CH-1:0] cmd_go_o,
	// interrupts
	output logic link_irq_o,
	output logic cmd_irq_o,
	output logic irq_o
);

	// ========================================
	// helpers

	// byte enables widened to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : lane_mask

	// a write of the given offset takes effect this cycle
	function automatic logic hit(input logic take, input logic [7:0] a,
		input logic [7:0] ofs);
		hit = take && (a == ofs);
	endfunction : hit

	// ========================================
	// bus slave handshake

	mle_avs_req_t req;
	mle_bus_state_t bus_state;
	mle_bus_state_t next_bus_state;
	logic wr_take;
	logic rd_take;
	logic [31:0] wmask_data;

	assign req = '{read: avs_read_i, write: avs_write_i,
		address: avs_address_i, byteenable: avs_byteenable_i,
		writedata: avs_writedata_i};

	// one wait cycle: read data is formed, then served with waitrequest low
	assign avs_waitrequest_o = (req.read || req.write) &&
		(bus_state == BUS_WAIT);
	assign wr_take = req.write && (bus_state == BUS_SERVE);
	assign rd_take = req.read && (bus_state == BUS_WAIT);
	// disabled lanes write zero, which w1c and w1s fields ignore
	assign wmask_data = req.writedata & lane_mask(req.byteenable);

	// handshake state: serve the cycle after a request shows up
	always_comb begin
		next_bus_state = BUS_WAIT;
		case (bus_state)
			BUS_WAIT: begin
				if (req.read || req.write) begin
					next_bus_state = BUS_SERVE;
				end
			end
			BUS_SERVE: begin
				next_bus_state = BUS_WAIT;
			end
			default: begin
				next_bus_state = BUS_WAIT;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			bus_state <= BUS_WAIT;
		end else begin
			bus_state <= next_bus_state;
		end
	end

	// ========================================
	// connection-state vector

	logic [NUM_PHY-1:0] conn_state;
	logic [NUM_PHY-1:0] next_conn_state;
	logic new_bit;
	logic [NUM_CH-1:0] link_changed;
	logic [PHY_AW-1:0] phy_sel [NUM_CH];

	// only the frame engine writes here; bus writes never reach it
	always_comb begin
		next_conn_state = conn_state;
		new_bit = status_rpt_i.ack && status_rpt_i.link_up;
		if (status_rpt_i.valid) begin
			next_conn_state[status_rpt_i.phy_addr] = new_bit;
		end
	end

	// a change only counts for the phy each channel watches
	always_comb begin
		for (int k = 0; k < NUM_CH; k++) begin
			link_changed[k] = status_rpt_i.valid &&
				(status_rpt_i.phy_addr == phy_sel[k]) &&
				(conn_state[status_rpt_i.phy_addr] != new_bit);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			conn_state <= RST_CONN_STATE;
		end else begin
			conn_state <= next_conn_state;
		end
	end

	// ========================================
	// software control registers

	logic [PHY_AW-1:0] next_phy_sel [NUM_CH];
	logic [NUM_CH-1:0] link_irq_en;
	logic [NUM_CH-1:0] next_link_irq_en;
	logic [NUM_CH-1:0] cmd_mask;
	logic [NUM_CH-1:0] next_cmd_mask;
	logic [7:0] wa;

	assign wa = req.address;

	// enable and select fields live in byte lane 0
	always_comb begin
		next_phy_sel[0] = phy_sel[0];
		next_phy_sel[1] = phy_sel[1];
		next_link_irq_en = link_irq_en;
		next_cmd_mask = cmd_mask;
		if (hit(wr_take, wa, OFS_PHY_SEL0) && req.byteenable[0]) begin
			next_phy_sel[0] = req.writedata[PHY_AW-1:0];
		end
		if (hit(wr_take, wa, OFS_PHY_SEL1) && req.byteenable[0]) begin
			next_phy_sel[1] = req.writedata[PHY_AW-1:0];
		end
		if (hit(wr_take, wa, OFS_LINK_IRQ_EN) && req.byteenable[0]) begin
			next_link_irq_en = req.writedata[NUM_CH-1:0];
		end
		if (hit(wr_take, wa, OFS_CMD_MASK_SET)) begin
			next_cmd_mask = cmd_mask | wmask_data[NUM_CH-1:0];
		end
		if (hit(wr_take, wa, OFS_CMD_MASK_CLR)) begin
			next_cmd_mask = cmd_mask & ~wmask_data[NUM_CH-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			phy_sel[0] <= RST_PHY_SEL;
			phy_sel[1] <= RST_PHY_SEL;
			link_irq_en <= RST_ENABLES;
			cmd_mask <= RST_ENABLES;
		end else begin
			phy_sel[0] <= next_phy_sel[0];
			phy_sel[1] <= next_phy_sel[1];
			link_irq_en <= next_link_irq_en;
			cmd_mask <= next_cmd_mask;
		end
	end

	// ========================================
	// command channels and start bits

	logic [NUM_CH-1:0] cmd_go;
	logic [NUM_CH-1:0] next_cmd_go;
	logic [NUM_CH-1:0] go_set;
	logic [NUM_CH-1:0] cmd_finish;

	assign go_set[0] = hit(wr_take, wa, OFS_CMD_CH0) &&
		wmask_data[GO_BIT];
	assign go_set[1] = hit(wr_take, wa, OFS_CMD_CH1) &&
		wmask_data[GO_BIT];
	// a done pulse without a pending start is stray and ignored
	assign cmd_finish = cmd_done_i & cmd_go;

	// start bit drops itself when the engine reports the access done
	always_comb begin
		next_cmd_go = (cmd_go & ~cmd_finish) | go_set;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cmd_go <= RST_ENABLES;
		end else begin
			cmd_go <= next_cmd_go;
		end
	end

	assign cmd_go_o = cmd_go;

	// ========================================
	// event bits

	logic [NUM_CH-1:0] link_raw;
	logic [NUM_CH-1:0] next_link_raw;
	logic [NUM_CH-1:0] cmd_raw;
	logic [NUM_CH-1:0] next_cmd_raw;
	logic [NUM_CH-1:0] link_masked;
	logic [NUM_CH-1:0] cmd_masked;
	logic [NUM_CH-1:0] link_clr;
	logic [NUM_CH-1:0] cmd_clr;

	// clearing the masked view clears the event behind it
	always_comb begin
		link_clr = '0;
		cmd_clr = '0;
		if (hit(wr_take, wa, OFS_LINK_RAW) ||
			hit(wr_take, wa, OFS_LINK_MASKED)) begin
			link_clr = wmask_data[NUM_CH-1:0];
		end
		if (hit(wr_take, wa, OFS_CMD_RAW) ||
			hit(wr_take, wa, OFS_CMD_MASKED)) begin
			cmd_clr = wmask_data[NUM_CH-1:0];
		end
		// a new event in the clearing cycle survives
		next_link_raw = (link_raw & ~link_clr) | link_changed;
		next_cmd_raw = (cmd_raw & ~cmd_clr) | cmd_finish;
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			link_raw <= RST_EVENTS;
			cmd_raw <= RST_EVENTS;
		end else begin
			link_raw <= next_link_raw;
			cmd_raw <= next_cmd_raw;
		end
	end

	// masked views follow raw and enables with no extra storage
	assign link_masked = link_raw & link_irq_en;
	assign cmd_masked = cmd_raw & cmd_mask;

	// level requests, held until software clears the event or its enable or mask bit
	assign link_irq_o = |link_masked;
	assign cmd_irq_o = |cmd_masked;
	assign irq_o = link_irq_o || cmd_irq_o;

	// ========================================
	// read data path

	logic [31:0] rdata;
	logic [31:0] next_rdata;

	// unmapped offsets read as zero; reserved bits read as zero
	always_comb begin
		next_rdata = rdata;
		if (rd_take) begin
			next_rdata = 32'h0000_0000;
			if (wa == OFS_CONN_STATE) begin
				next_rdata = conn_state;
			end else if (wa == OFS_LINK_RAW) begin
				next_rdata[NUM_CH-1:0] = link_raw;
			end else if (wa == OFS_LINK_MASKED) begin
				next_rdata[NUM_CH-1:0] = link_masked;
			end else if (wa == OFS_CMD_RAW) begin
				next_rdata[NUM_CH-1:0] = cmd_raw;
			end else if (wa == OFS_CMD_MASKED) begin
				next_rdata[NUM_CH-1:0] = cmd_masked;
			end else if (wa == OFS_CMD_MASK_SET ||
				wa == OFS_CMD_MASK_CLR) begin
				next_rdata[NUM_CH-1:0] = cmd_mask;
			end else if (wa == OFS_LINK_IRQ_EN) begin
				next_rdata[NUM_CH-1:0] = link_irq_en;
			end else if (wa == OFS_PHY_SEL0) begin
				next_rdata[PHY_AW-1:0] = phy_sel[0];
			end else if (wa == OFS_PHY_SEL1) begin
				next_rdata[PHY_AW-1:0] = phy_sel[1];
			end else if (wa == OFS_CMD_CH0) begin
				next_rdata[GO_BIT] = cmd_go[0];
			end else if (wa == OFS_CMD_CH1) begin
				next_rdata[GO_BIT] = cmd_go[1];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign avs_readdata_o = rdata;

endmodule : mle_events

`default_nettype wire

// [dv/mle_events_asserts.sv]
// checker of command and interrupt timing at the event block ports
`timescale 1ns/1ps
`default_nettype none

module mle_events_asserts
	import mle_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// watched ports
	input wire logic avs_write_i,
	input wire logic [BUS_AW-1:0] avs_address_i,
	input wire mle_status_rpt_t status_rpt_i,
	input wire logic [NUM_CH-1:0] cmd_done_i,
	input wire logic [NUM_CH-1:0] cmd_go_o,
	input wire logic link_irq_o,
	input wire logic cmd_irq_o,
	input wire logic irq_o
);
	// ========================================
	// properties, one clock domain
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	chk_irq_combined: assert property (irq_o == (link_irq_o | cmd_irq_o))
		else $error("combined irq differs from its parts");
	// only a write may lower a set request, so events stay sticky
	chk_link_sticky: assert property (link_irq_o && !avs_write_i |=> link_irq_o)
		else $error("link irq dropped without a write");
	chk_cmd_sticky: assert property (cmd_irq_o && !avs_write_i |=> cmd_irq_o)
		else $error("command irq dropped without a write");
	chk_link_cause: assert property ($rose(link_irq_o) |->
		$past(status_rpt_i.valid) || $past(avs_write_i))
		else $error("link irq rose with no report or write");
	chk_cmd_cause: assert property ($rose(cmd_irq_o) |->
		$past(cmd_done_i[0] | cmd_done_i[1]) || $past(avs_write_i))
		else $error("command irq rose with no done or write");
	chk_go_clears: assert property (cmd_done_i[0] && cmd_go_o[0] &&
		!avs_write_i |=> !cmd_go_o[0])
		else $error("start bit did not self-clear");
	chk_go_holds: assert property (cmd_go_o[1] && !cmd_done_i[1] |=> cmd_go_o[1])
		else $error("start bit dropped before done");
	chk_go_source: assert property ($rose(cmd_go_o[0]) |->
		$past(avs_write_i) && $past(avs_address_i) == OFS_CMD_CH0)
		else $error("start bit rose without its write");
endmodule : mle_events_asserts

bind mle_events mle_events_asserts u_chk (
	.clk_i(clk_i),
	.nrst_i(nrst_i),
	.avs_write_i(avs_write_i),
	.avs_address_i(avs_address_i),
	.status_rpt_i(status_rpt_i),
	.cmd_done_i(cmd_done_i),
	.cmd_go_o(cmd_go_o),
	.link_irq_o(link_irq_o),
	.cmd_irq_o(cmd_irq_o),
	.irq_o(irq_o)
);

`default_nettype wire

// [dv/mle_phy_model.sv]
// far side model: frame engine and phys answering reads and commands
`timescale 1ns/1ps
`default_nettype none

module mle_phy_model
	import mle_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// from the bench
	input wire logic poll_i,
	input wire logic [PHY_AW-1:0] addr_i,
	input wire logic [NUM_PHY-1:0] ack_i,
	input wire logic [NUM_PHY-1:0] link_i,
	input wire logic [7:0] dly_i,
	// to and from the event block
	input wire logic [NUM_CH-1:0] go_i,
	output var mle_status_rpt_t rpt_o = '0,
	output var logic [NUM_CH-1:0] done_o = '0
);
	logic [7:0] cnt [NUM_CH] = '{8'h00, 8'h00};

	// ========================================
	// status reads; idle fields toggle so stale values never help
	always @(posedge clk_i) begin
		rpt_o.valid <= poll_i & nrst_i;
		rpt_o.phy_addr <= poll_i ? addr_i : ~rpt_o.phy_addr;
		rpt_o.ack <= poll_i ? ack_i[addr_i] : ~rpt_o.ack;
		rpt_o.link_up <= poll_i ? link_i[addr_i] : ~rpt_o.link_up;
	end

	// ========================================
	// a command ends dly_i+1 cycles after go, as a single pulse
	always @(posedge clk_i) begin
		for (int c = 0; c < NUM_CH; c++) begin
			done_o[c] <= 1'b0;
			if (!nrst_i || !go_i[c] || done_o[c]) cnt[c] <= 8'h00;
			else if (cnt[c] == dly_i) done_o[c] <= 1'b1;
			else cnt[c] <= cnt[c] + 8'h01;
		end
	end
endmodule : mle_phy_model

`default_nettype wire

// [dv/test_mdio_link_and_command_events.sv]
// self-checking bench of the mdio link and command events
`timescale 1ns/1ps
`default_nettype none

module test_mdio_link_and_command_events
	import mle_pkg::*;
;
	logic clk_i = 0, nrst_i = 0, rd = 0, wr = 0, poll = 0;
	logic [7:0] adr = 8'h00, dly = 8'h00;
	logic [31:0] wd = 0, lk = 0, ak = 0, q, r, seed = 32'h0000_d738;
	logic [4:0] pa = 5'h00;
	wire logic [31:0] rdat;
	wire logic wt, lirq, cirq, irq;
	wire logic [1:0] go, done;
	wire mle_status_rpt_t rpt;
	int n_mismatch = 0, n_tests = 0, i, k;
	// reference model state
	logic [31:0] conn = 0;
	logic [1:0] lraw = 0, len = 0, craw = 0, cmsk = 0, mgo = 0;
	logic [4:0] sel [2] = '{5'h00, 5'h00};

	// ========================================
	// clock, design and far side
	always #20 clk_i = ~clk_i;

	mle_events u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_read_i(rd),
		.avs_write_i(wr), .avs_address_i(adr), .avs_byteenable_i(4'hf),
		.avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wt),
		.status_rpt_i(rpt), .cmd_done_i(done), .cmd_go_o(go),
		.link_irq_o(lirq), .cmd_irq_o(cirq), .irq_o(irq));
	mle_phy_model u_phy (.clk_i(clk_i), .nrst_i(nrst_i), .poll_i(poll),
		.addr_i(pa), .ack_i(ak), .link_i(lk), .dly_i(dly), .go_i(go),
		.rpt_o(rpt), .done_o(done));

	// ========================================
	// helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	function automatic logic [31:0] ex(input logic [7:0] a);
		case (a)
			OFS_CONN_STATE: return conn;
			OFS_LINK_RAW: return {30'h0, lraw};
			OFS_LINK_MASKED: return {30'h0, lraw & len};
			OFS_CMD_RAW: return {30'h0, craw};
			OFS_CMD_MASKED: return {30'h0, craw & cmsk};
			OFS_CMD_MASK_SET, OFS_CMD_MASK_CLR: return {30'h0, cmsk};
			OFS_LINK_IRQ_EN: return {30'h0, len};
			OFS_PHY_SEL0: return {27'h0, sel[0]};
			OFS_PHY_SEL1: return {27'h0, sel[1]};
			OFS_CMD_CH0: return {mgo[0], 31'h0};
			OFS_CMD_CH1: return {mgo[1], 31'h0};
			default: return 32'h0;
		endcase
	endfunction : ex

	task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	// one avalon access; waitrequest and read data taken at one rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		// right after an edge the registers still show what it sampled
		@(posedge clk_i);
		while (wt !== 1'b0 && n < 50) begin
			n++;
			@(posedge clk_i);
		end
		if (n == 50) n_mismatch++;
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task wrm(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		case (a)
			OFS_LINK_RAW, OFS_LINK_MASKED: lraw &= ~d[1:0];
			OFS_CMD_RAW, OFS_CMD_MASKED: craw &= ~d[1:0];
			OFS_CMD_MASK_SET: cmsk |= d[1:0];
			OFS_CMD_MASK_CLR: cmsk &= ~d[1:0];
			OFS_LINK_IRQ_EN: len = d[1:0];
			OFS_PHY_SEL0: sel[0] = d[4:0];
			OFS_PHY_SEL1: sel[1] = d[4:0];
			OFS_CMD_CH0: mgo[0] |= d[31];
			OFS_CMD_CH1: mgo[1] |= d[31];
			default: ;
		endcase
	endtask : wrm

	task rc(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
		cmp($sformatf("reg %h", a), ex(a), q);
	endtask : rc

	task irqc();
		logic a, b;
		a = |(lraw & len);
		b = |(craw & cmsk);
		cmp("irq", {29'h0, a, b, a | b}, {29'h0, lirq, cirq, irq});
	endtask : irqc

	// one status read of a phy; the report lands two edges later
	task pl(input logic [4:0] a, input logic ak1, input logic lk1);
		logic o;
		@(posedge clk_i);
		poll <= 1'b1;
		pa <= a;
		ak[a] <= ak1;
		lk[a] <= lk1;
		@(posedge clk_i);
		poll <= 1'b0;
		repeat (2) @(posedge clk_i);
		o = conn[a];
		conn[a] = ak1 & lk1;
		for (int c = 0; c < 2; c++) if (sel[c] == a && o != conn[a]) lraw[c] = 1;
	endtask : pl

	task close_out();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out

	// ========================================
	// watchdog, far beyond the several hundred cycles needed
	initial begin
		repeat (8000) @(posedge clk_i);
		n_mismatch++;
		close_out();
	end

	// ========================================
	// tests
	initial begin
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		for (i = 0; i <= 48; i += 4) rc(i[7:0]);
		$display("test reset values done");
		wrm(OFS_CONN_STATE, xs());
		rc(OFS_CONN_STATE);
		wrm(OFS_PHY_SEL0, 32'h3);
		wrm(OFS_PHY_SEL1, xs());
		wrm(OFS_LINK_IRQ_EN, 32'h1);
		// random reports, biased to the selected phys
		for (i = 0; i < 40; i++) begin
			r = xs();
			k = r[8] ? 3 : (r[9] ? sel[1] : r[4:0]);
			pl(k[4:0], r[10] | r[11], r[12]);
			rc(OFS_CONN_STATE);
			rc(OFS_LINK_RAW);
			rc(OFS_LINK_MASKED);
			irqc();
			if (r[13]) wrm(r[14] ? OFS_LINK_MASKED : OFS_LINK_RAW, r);
			if (i == 20) wrm(OFS_LINK_IRQ_EN, 32'h2);
		end
		$display("test link events done");
		wrm(OFS_CMD_MASK_SET, 32'h1);
		// channel 0 answers at once, channel 1 slowly
		for (i = 0; i < 2; i++) begin
			dly <= i ? 8'h09 : 8'h00;
			wrm(i ? OFS_CMD_CH1 : OFS_CMD_CH0, 32'h8000_0000);
			if (i == 1) rc(OFS_CMD_CH1);
			k = 0;
			// the start bit only shows after the write edge, so step first
			do begin
				k++;
				@(posedge clk_i);
			end while (go[i] !== 1'b0 && k < 100);
			if (k == 100) n_mismatch++;
			mgo[i] = 1'b0;
			craw[i] = 1'b1;
			rc(OFS_CMD_RAW);
			rc(OFS_CMD_MASKED);
			irqc();
		end
		wrm(OFS_CMD_MASKED, 32'h1);
		rc(OFS_CMD_RAW);
		wrm(OFS_CMD_MASK_CLR, 32'h1);
		wrm(OFS_CMD_MASK_SET, 32'h2);
		rc(OFS_CMD_MASKED);
		irqc();
		wrm(OFS_CMD_RAW, 32'h3);
		// let the clearing edge settle before looking at the requests
		@(posedge clk_i);
		irqc();
		$display("test command events done");
		close_out();
	end
endmodule : test_mdio_link_and_command_events

`default_nettype wire
